// ==== carr_regs.sv ====
// read-only measurement result registers of the charger converter
`timescale 1ns/1ps
module carr_regs
  import carr_pkg::*;
#(
  parameter int RES_W = CARR_RES_W
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic RES_WR,
  input wire logic [CARR_IDX_W-1:0] RES_SEL,
  input wire logic [RES_W-1:0] RES_DATA,
  input wire logic REG_RST_CMD,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [CARR_AW-1:0] REG_ADDR,
  input wire logic [CARR_DW-1:0] REG_WDATA,
  output logic [CARR_DW-1:0] REG_RDATA,
  output logic REG_RVALID,
  output logic REG_RHIT
);
  logic [CARR_IDX_W-1:0] rd_idx;
  logic rd_high;
  logic rd_hit;
  logic [RES_W-1:0] mem_rdata;
  logic pend_reg;
  logic pend_high_reg;
  logic pend_hit_reg;

  initial begin
    if (RES_W != 2 * CARR_DW) begin
      $error("carr_regs: RES_W must be two register bytes");
    end
  end

  // address to {hit, high byte, entry}
  function automatic logic [CARR_IDX_W+1:0] map_addr(input logic [CARR_AW-1:0] a);
    logic [CARR_IDX_W+1:0] m;
    m = '0;
    unique case (a)
      CARR_OUTPUT_VOLTAGE_LOW_ADDR: m = {1'b1, 1'b0, CARR_IDX_OUTPUT_VOLTAGE};
      CARR_BATTERY_VOLTAGE_HIGH_ADDR: m = {1'b1, 1'b1, CARR_IDX_BATTERY_VOLTAGE};
      CARR_BATTERY_VOLTAGE_LOW_ADDR: m = {1'b1, 1'b0, CARR_IDX_BATTERY_VOLTAGE};
      CARR_BATTERY_CURRENT_HIGH_ADDR: m = {1'b1, 1'b1, CARR_IDX_BATTERY_CURRENT};
      CARR_BATTERY_CURRENT_LOW_ADDR: m = {1'b1, 1'b0, CARR_IDX_BATTERY_CURRENT};
      default: m = '0;
    endcase
    return m;
  endfunction

  always_comb begin
    {rd_hit, rd_high, rd_idx} = map_addr(REG_ADDR);
  end

  // host write port never reaches the store
  carr_result_mem #(
    .W(RES_W),
    .DEPTH(CARR_ENTRY_N),
    .AW(CARR_IDX_W)
  ) u_mem (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .clr(REG_RST_CMD),
    .wr_en(RES_WR),
    .wr_idx(RES_SEL),
    .wr_data(RES_DATA),
    .rd_idx(rd_idx),
    .rd_data(mem_rdata)
  );

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pend_reg <= 1'b0;
      pend_high_reg <= 1'b0;
      pend_hit_reg <= 1'b0;
    end else begin
      pend_reg <= REG_RD;
      pend_high_reg <= rd_high;
      pend_hit_reg <= rd_hit;
    end
  end

  // byte lane select of the stored result
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= CARR_RDATA_RESET;
      REG_RVALID <= 1'b0;
      REG_RHIT <= 1'b0;
    end else begin
      REG_RVALID <= pend_reg;
      REG_RHIT <= pend_reg && pend_hit_reg;
      if (!pend_reg) begin
        REG_RDATA <= REG_RDATA;
      end else if (!pend_hit_reg) begin
        REG_RDATA <= CARR_UNMAPPED_DATA;
      end else if (pend_high_reg) begin
        REG_RDATA <= mem_rdata[CARR_SIGN_BIT -: CARR_DW];
      end else begin
        REG_RDATA <= mem_rdata[CARR_LOW_LSB +: CARR_DW];
      end
    end
  end

  logic unused_wr;
  assign unused_wr = REG_WR ^ (^REG_WDATA);
endmodule // carr_regs

// ==== carr_pkg.sv ====
// constants shared by the charger result register bank
package carr_pkg;
  localparam int CARR_AW = 8;
  localparam int CARR_DW = 8;
  localparam int CARR_RES_W = 16;
  localparam int CARR_ENTRY_N = 3;
  localparam int CARR_IDX_W = 2;
  localparam logic [CARR_AW-1:0] CARR_OUTPUT_VOLTAGE_LOW_ADDR = 8'h1D;
  localparam logic [CARR_AW-1:0] CARR_BATTERY_VOLTAGE_HIGH_ADDR = 8'h1E;
  localparam logic [CARR_AW-1:0] CARR_BATTERY_VOLTAGE_LOW_ADDR = 8'h1F;
  localparam logic [CARR_AW-1:0] CARR_BATTERY_CURRENT_HIGH_ADDR = 8'h20;
  localparam logic [CARR_AW-1:0] CARR_BATTERY_CURRENT_LOW_ADDR = 8'h21;
  localparam logic [CARR_IDX_W-1:0] CARR_IDX_OUTPUT_VOLTAGE = 2'h0;
  localparam logic [CARR_IDX_W-1:0] CARR_IDX_BATTERY_VOLTAGE = 2'h1;
  localparam logic [CARR_IDX_W-1:0] CARR_IDX_BATTERY_CURRENT = 2'h2;
  localparam int CARR_SIGN_BIT = 15;
  localparam int CARR_HIGH_LSB = 8;
  localparam int CARR_LOW_LSB = 0;
  localparam logic [CARR_RES_W-1:0] CARR_RES_RESET = 16'h0000;
  localparam logic [CARR_DW-1:0] CARR_RDATA_RESET = 8'h00;
  localparam logic [CARR_DW-1:0] CARR_UNMAPPED_DATA = 8'h00;
endpackage

// ==== carr_result_mem.sv ====
// small result store with registered read data
`timescale 1ns/1ps
module carr_result_mem #(
  parameter int W = 16,
  parameter int DEPTH = 3,
  parameter int AW = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_idx,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_reg [DEPTH];

  initial begin
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin
      $error("carr_result_mem: DEPTH does not fit AW");
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_reg[i] <= '0;
      end else if (wr_en && wr_idx == AW'(i)) begin
        // new result beats a same-cycle clear
        mem_reg[i] <= wr_data;
      end else if (clr) begin
        mem_reg[i] <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (int'(rd_idx) < DEPTH) begin
      rd_data <= mem_reg[rd_idx];
    end else begin
      rd_data <= '0;
    end
  end
endmodule // carr_result_mem

// ==== carr_regs_asserts.sv ====
// port assertions for the result register bank
`timescale 1ns/1ps
module carr_regs_chk (
  input logic REF_CLK,
  input logic RSTN,
  input logic RES_WR,
  input logic [1:0] RES_SEL,
  input logic [15:0] RES_DATA,
  input logic REG_RST_CMD,
  input logic REG_RD,
  input logic [7:0] REG_ADDR,
  input logic [7:0] REG_RDATA,
  input logic REG_RVALID,
  input logic REG_RHIT
);
  logic map;
  assign map = REG_ADDR inside {[8'h1D:8'h21]};
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  a_rd_answer: assert property (REG_RD |-> ##2 REG_RVALID) else $error("no answer");
  a_no_spur: assert property (!$past(REG_RD,2) |-> !REG_RVALID) else $error("spurious");
  a_hit_map: assert property (REG_RD && map |-> ##2 REG_RHIT) else $error("no hit");
  a_miss_zero: assert property (REG_RD && !map |-> ##2 !REG_RHIT && REG_RDATA == 8'h00)
    else $error("bad miss");
  a_data_hold: assert property ($changed(REG_RDATA) |-> REG_RVALID) else $error("moved");
  a_clr_zero: assert property (REG_RST_CMD && !RES_WR ##[1:3] REG_RD && !RES_WR
    |-> ##2 REG_RDATA == 8'h00) else $error("not cleared");
  a_vbat_high: assert property (RES_WR && RES_SEL == 2'h1 ##1 !RES_WR ##1 REG_RD &&
    REG_ADDR == 8'h1E |-> ##2 REG_RDATA == $past(RES_DATA[15:8],4)) else $error("vbat hi");
  a_ibat_low: assert property (RES_WR && RES_SEL == 2'h2 ##1 !RES_WR ##1 REG_RD &&
    REG_ADDR == 8'h21 |-> ##2 REG_RDATA == $past(RES_DATA[7:0],4)) else $error("ibat lo");
  c_hit: cover property (REG_RVALID && REG_RHIT);
  c_miss: cover property (REG_RVALID && !REG_RHIT);
  c_clear: cover property (REG_RST_CMD);
endmodule // carr_regs_chk
bind carr_regs carr_regs_chk chk (.*);

// ==== carr_host.sv ====
// host model issuing register reads and writes
`timescale 1ns/1ps
module carr_host (
  input logic clk,
  input logic [7:0] rdata,
  output logic rd = 1'b0,
  output logic wr = 1'b0,
  output logic [7:0] addr = 8'hFF,
  output logic [7:0] wdata = 8'hFF
);
  task automatic acc(input logic w, input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= 8'h55;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    addr <= ~a;
    wdata <= 8'hAA;
    repeat (2) @(posedge clk);
    #1 d = rdata;
  endtask
endmodule // carr_host

// ==== carr_regs_tb_top.sv ====
// testbench for the result register bank
`timescale 1ns/1ps
module carr_regs_tb_top;
  import carr_pkg::*;
  logic clk, rstn, res_wr, rst_cmd, rd, wr, rvalid, rhit;
  logic [1:0] sel;
  logic [15:0] data;
  logic [7:0] addr, wdata, rdata, got;
  int n_errors = 0;
  int n_checks = 0;
  logic [33:0] rows [7] = '{{2'h0,16'h1234,8'h1D,8'h34}, {2'h1,16'h8ABC,8'h1E,8'h8A},
    {2'h1,16'h8ABC,8'h1F,8'hBC}, {2'h2,16'hFF38,8'h20,8'hFF}, {2'h2,16'h0190,8'h21,8'h90},
    {2'h3,16'h5555,8'h1E,8'h8A}, {2'h0,16'h1234,8'h1C,8'h00}};
  carr_regs DUT (.REF_CLK(clk), .RSTN(rstn), .RES_WR(res_wr), .RES_SEL(sel), .RES_DATA(data),
    .REG_RST_CMD(rst_cmd), .REG_RD(rd), .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_RHIT(rhit));
  carr_host host (.clk(clk), .rdata(rdata), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata));
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    n_errors++;
    end_of_test;
  end
  initial begin
    {rstn, res_wr, rst_cmd, sel, data} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    host.acc(1'b0, 8'h1E, got);
    chk(got, CARR_RDATA_RESET);
    foreach (rows[i]) begin
      @(posedge clk);
      {res_wr, sel, data} <= {1'b1, rows[i][33:16]};
      @(posedge clk);
      res_wr <= 1'b0;
      host.acc(1'b0, rows[i][15:8], got);
      chk(got, rows[i][7:0]);
    end
    host.acc(1'b1, 8'h1E, got);
    host.acc(1'b0, 8'h1E, got);
    chk(got, 8'h8A);
    @(posedge clk);
    rst_cmd <= 1'b1;
    @(posedge clk);
    rst_cmd <= 1'b0;
    host.acc(1'b0, 8'h21, got);
    chk(got, 8'h00);
    end_of_test;
  end
endmodule // carr_regs_tb_top
